// [hdl/rsfg_regs.sv]
// receive synthesizer / filter / output pin register slice behind the four-wire port
//
// Summary of operation
// - loop-filter adjust bit 11: 0 selects WCDMA filter, 1 is invalid
// - prescaler field: 01 cellular ratio, 10 PCS ratio
// - VCO select: 00 off, 01 low VCO, 10 high VCO, 11 unused
// - high-VCO band: 00 IMT, 01 PCS, 11 must be avoided
// - bit 17 of filter register: 0 normal, 1 bypass receive filter
// - bandwidth mode bits 23-25: 000 WCDMA, 011 GSM, others undefined
// - third output mux select split: low bit 1, high bit 17
// - mux: rx lock, tx lock, static level, AND of all three locks
// - output select fields: 00/01 high-Z, 10 drive low, 11 drive high
// - writing 1 to bit 6 starts a temperature reading
// - temperature result in bits 7-11, returned on readback
// - bits 20-21 set serial data-out drive 1x to 4x
`timescale 1ns/1ps
module rsfg_regs
	import rsfg_pkg::*;
(
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         reset,
	// four-wire serial port
	input  wire logic         serCsN,
	input  wire logic         serClk,
	input  wire logic         serDin,
	output logic              serDout,
	output logic              serDoutOe,
	output logic [1:0]        serialOutDriveStrength,
	// pll lock flags from analog
	input  wire rsfg_lock_t   lockFlags,
	// temperature sensor
	output logic              tempReadStart,
	input  wire logic         tempResultValid,
	input  wire logic [4:0]   tempResult,
	// general outputs
	output logic              generalOutputTwo,
	output logic              generalOutputTwoOe,
	output logic              generalOutputThree,
	output logic              generalOutputThreeOe,
	// decoded configuration
	output rsfg_rx_cfg_t      rxCfg,
	output logic              lowBandVcoOn,
	output logic              highBandVcoOn,
	output logic              cfgFault
);
	// ==========================================================
	// pin synchronisers
	logic [2:0]       pinMeta_reg;
	logic [2:0]       pinSync_reg;
	logic             clkPrev_reg;
	rsfg_lock_t       lockMeta_reg;
	rsfg_lock_t       lockSync_reg;
	logic             csN;
	logic             din;
	logic             clkRise;
	logic             clkFall;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pinMeta_reg  <= 3'h1;
			pinSync_reg  <= 3'h1;
			clkPrev_reg  <= 1'b0;
			lockMeta_reg <= '0;
			lockSync_reg <= '0;
		end else begin
			pinMeta_reg  <= {serClk, serDin, serCsN};
			pinSync_reg  <= pinMeta_reg;
			clkPrev_reg  <= pinSync_reg[2];
			lockMeta_reg <= lockFlags;
			lockSync_reg <= lockMeta_reg;
		end
	end
	assign csN     = pinSync_reg[0];
	assign din     = pinSync_reg[1];
	assign clkRise = pinSync_reg[2] & ~clkPrev_reg;
	assign clkFall = ~pinSync_reg[2] & clkPrev_reg;
	// ==========================================================
	// serial frame engine: read flag, 5 address bits, 26 data bits, msb first
	rsfg_ser_state_t  state_reg,    state_next;
	logic [4:0]       bitCnt_reg,   bitCnt_next;
	logic             isRead_reg,   isRead_next;
	logic [4:0]       addr_reg,     addr_next;
	logic [25:0]      shiftIn_reg,  shiftIn_next;
	logic [25:0]      shiftOut_reg, shiftOut_next;
	logic             doutOe_reg,   doutOe_next;
	logic             doutBit_reg,  doutBit_next;
	logic             wrStb;
	logic [25:0]      regs_reg [ADDR_FIRST:ADDR_LAST];
	logic [25:0]      readWord;
	always_comb begin
		readWord = '0;
		if (addr_next >= ADDR_RX_VCO_CONFIG && addr_next <= ADDR_OUTPUT_PIN_CONFIG) begin
			readWord = regs_reg[addr_next];
		end
	end
	always_comb begin
		state_next    = state_reg;
		bitCnt_next   = bitCnt_reg;
		isRead_next   = isRead_reg;
		addr_next     = addr_reg;
		shiftIn_next  = shiftIn_reg;
		shiftOut_next = shiftOut_reg;
		wrStb         = 1'b0;
		case (state_reg)
			SER_IDLE: begin
				bitCnt_next = '0;
				if (!csN) begin
					state_next = SER_HEAD;
				end
			end
			SER_HEAD: begin
				if (clkRise) begin
					{isRead_next, addr_next} = {addr_reg, din};
					bitCnt_next = bitCnt_reg + 5'h01;
					if (bitCnt_reg == HEAD_LAST) begin
						bitCnt_next   = '0;
						state_next    = SER_DATA;
						shiftOut_next = readWord;
					end
				end
			end
			SER_DATA: begin
				if (clkRise) begin
					shiftIn_next = {shiftIn_reg[24:0], din};
					bitCnt_next  = bitCnt_reg + 5'h01;
					if (bitCnt_reg == DATA_LAST) begin
						wrStb      = ~isRead_reg;
						state_next = SER_DONE;
					end
				end else if (clkFall) begin
					shiftOut_next = {shiftOut_reg[24:0], 1'b0};
				end
			end
			SER_DONE: begin
				state_next = SER_DONE;
			end
			default: begin
				state_next = SER_IDLE;
			end
		endcase
		// a raised select aborts any frame; a partial write is dropped
		if (csN) begin
			state_next = SER_IDLE;
		end
		doutOe_next  = (state_next == SER_DATA) & isRead_next;
		doutBit_next = shiftOut_next[25];
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg    <= SER_IDLE;
			bitCnt_reg   <= '0;
			isRead_reg   <= 1'b0;
			addr_reg     <= '0;
			shiftIn_reg  <= '0;
			shiftOut_reg <= '0;
			doutOe_reg   <= 1'b0;
			doutBit_reg  <= 1'b0;
		end else begin
			state_reg    <= state_next;
			bitCnt_reg   <= bitCnt_next;
			isRead_reg   <= isRead_next;
			addr_reg     <= addr_next;
			shiftIn_reg  <= shiftIn_next;
			shiftOut_reg <= shiftOut_next;
			doutOe_reg   <= doutOe_next;
			doutBit_reg  <= doutBit_next;
		end
	end

	// ==========================================================
	// register file; unmapped addresses ignore writes and read zero
	logic [25:0]      regs_next [ADDR_FIRST:ADDR_LAST];
	logic             tempStart_next;
	logic             tempStart_reg;
	always_comb begin
		for (int i = ADDR_FIRST; i <= ADDR_LAST; i++) begin
			regs_next[i] = regs_reg[i];
		end
		tempStart_next = 1'b0;
		if (wrStb && addr_reg >= ADDR_RX_VCO_CONFIG && addr_reg <= ADDR_OUTPUT_PIN_CONFIG) begin
			regs_next[addr_reg] = shiftIn_next;
		end
		if (wrStb && addr_reg == ADDR_OUTPUT_PIN_CONFIG) begin
			tempStart_next = shiftIn_next[POS_TEMP_TRIG];
			// result bits are read-only: keep the measured value
			regs_next[ADDR_LAST][POS_TEMP_RESULT +: 5] =
				regs_reg[ADDR_LAST][POS_TEMP_RESULT +: 5];
		end
		// a finishing measurement wins over a simultaneous write
		if (tempResultValid) begin
			regs_next[ADDR_LAST][POS_TEMP_RESULT +: 5] = tempResult;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = ADDR_FIRST; i <= ADDR_LAST; i++) begin
				regs_reg[i] <= REG_RESET;
			end
			tempStart_reg <= 1'b0;
		end else begin
			for (int i = ADDR_FIRST; i <= ADDR_LAST; i++) begin
				regs_reg[i] <= regs_next[i];
			end
			tempStart_reg <= tempStart_next;
		end
	end

	// ==========================================================
	// decoded outputs
	logic [1:0]       muxSel;
	logic [1:0]       selTwo;
	logic [1:0]       selThree;
	logic [25:0]      vcoReg;
	logic [25:0]      lpfReg;
	logic             outTwo_next,   outTwoOe_next;
	logic             outThree_next, outThreeOe_next;
	logic             lowVco_next,   highVco_next,   fault_next;
	logic             outTwo_reg,    outTwoOe_reg;
	logic             outThree_reg,  outThreeOe_reg;
	logic             lowVco_reg,    highVco_reg,    fault_reg;
	rsfg_rx_cfg_t     rxCfg_next,    rxCfg_reg;
	assign vcoReg   = regs_reg[ADDR_FIRST];
	assign lpfReg   = regs_reg[ADDR_LAST - 1];
	assign muxSel   = {regs_reg[ADDR_LAST][POS_MUX_HIGH], regs_reg[ADDR_LAST][POS_MUX_LOW]};
	assign selTwo   = regs_reg[ADDR_LAST][POS_OUT_TWO +: 2];
	assign selThree = regs_reg[ADDR_LAST][POS_OUT_THREE +: 2];
	always_comb begin
		rxCfg_next.loopFilterAdjust = vcoReg[POS_LOOP_FILTER];
		rxCfg_next.prescalerCfg     = vcoReg[POS_PRESCALER +: 2];
		rxCfg_next.vcoChoice        = vcoReg[POS_VCO_CHOICE +: 2];
		rxCfg_next.highVcoBand      = vcoReg[POS_HIGH_BAND +: 2];
		rxCfg_next.filterSkip       = lpfReg[POS_FILTER_SKIP];
		rxCfg_next.bandwidthMode    = lpfReg[POS_BW_MODE +: 3];
		lowVco_next  = rxCfg_next.vcoChoice == VCO_LOW;
		highVco_next = rxCfg_next.vcoChoice == VCO_HIGH;
		// invalid codes are flagged rather than remapped
		fault_next = rxCfg_next.loopFilterAdjust
			| (rxCfg_next.prescalerCfg != PRESC_CELL && rxCfg_next.prescalerCfg != PRESC_PCS)
			| (rxCfg_next.vcoChoice == 2'h3)
			| (rxCfg_next.highVcoBand != BAND_IMT && rxCfg_next.highVcoBand != BAND_PCS)
			| (rxCfg_next.bandwidthMode != BW_WCDMA && rxCfg_next.bandwidthMode != BW_GSM);
		outTwoOe_next = selTwo[1];
		outTwo_next   = selTwo[0];
		case (muxSel)
			MUX_RX_LOCK: begin
				outThreeOe_next = 1'b1;
				outThree_next   = lockSync_reg.rxLock;
			end
			MUX_TX_LOCK: begin
				outThreeOe_next = 1'b1;
				outThree_next   = lockSync_reg.txLock;
			end
			MUX_STATIC: begin
				outThreeOe_next = selThree[1];
				outThree_next   = selThree[0];
			end
			default: begin
				outThreeOe_next = 1'b1;
				outThree_next   = &lockSync_reg;
			end
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rxCfg_reg      <= '0;
			lowVco_reg     <= 1'b0;
			highVco_reg    <= 1'b0;
			fault_reg      <= 1'b0;
			outTwo_reg     <= 1'b0;
			outTwoOe_reg   <= 1'b0;
			outThree_reg   <= 1'b0;
			outThreeOe_reg <= 1'b0;
		end else begin
			rxCfg_reg      <= rxCfg_next;
			lowVco_reg     <= lowVco_next;
			highVco_reg    <= highVco_next;
			fault_reg      <= fault_next;
			outTwo_reg     <= outTwo_next;
			outTwoOe_reg   <= outTwoOe_next;
			outThree_reg   <= outThree_next;
			outThreeOe_reg <= outThreeOe_next;
		end
	end
	assign serDout                = doutBit_reg;
	assign serDoutOe              = doutOe_reg;
	assign serialOutDriveStrength = regs_reg[ADDR_LAST][POS_DRIVE +: 2];
	assign tempReadStart          = tempStart_reg;
	assign generalOutputTwo       = outTwo_reg;
	assign generalOutputTwoOe     = outTwoOe_reg;
	assign generalOutputThree     = outThree_reg;
	assign generalOutputThreeOe   = outThreeOe_reg;
	assign rxCfg                  = rxCfg_reg;
	assign lowBandVcoOn           = lowVco_reg;
	assign highBandVcoOn          = highVco_reg;
	assign cfgFault               = fault_reg;
endmodule

// [hdl/rsfg_pkg.sv]
// shared constants and types for the receive config / output pin register slice
package rsfg_pkg;

	// ==========================================================
	// frame and register geometry
	localparam int          REG_W        = 26;
	localparam int          ADDR_W       = 5;
	localparam int          HEAD_BITS    = 6;
	localparam logic [4:0]  HEAD_LAST    = 5'h05;
	localparam logic [4:0]  DATA_LAST    = 5'h19;
	localparam logic [25:0] REG_RESET    = 26'h0000000;

	// ==========================================================
	// register offsets
	localparam logic [4:0]  ADDR_RX_VCO_CONFIG      = 5'h03;
	localparam logic [4:0]  ADDR_RESERVED_FOUR      = 5'h04;
	localparam logic [4:0]  ADDR_RESERVED_FIVE      = 5'h05;
	localparam logic [4:0]  ADDR_RX_BASEBAND_FILTER = 5'h06;
	localparam logic [4:0]  ADDR_OUTPUT_PIN_CONFIG  = 5'h07;
	localparam int          ADDR_FIRST              = 3;
	localparam int          ADDR_LAST               = 7;

	// ==========================================================
	// rx_vco_config fields
	localparam int          POS_LOOP_FILTER  = 11;
	localparam int          POS_PRESCALER    = 17;
	localparam int          POS_VCO_CHOICE   = 19;
	localparam int          POS_HIGH_BAND    = 21;

	// rx_baseband_filter fields
	localparam int          POS_FILTER_SKIP  = 17;
	localparam int          POS_BW_MODE      = 23;

	// output_pin_config fields
	localparam int          POS_MUX_LOW      = 1;
	localparam int          POS_OUT_TWO      = 2;
	localparam int          POS_OUT_THREE    = 4;
	localparam int          POS_TEMP_TRIG    = 6;
	localparam int          POS_TEMP_RESULT  = 7;
	localparam int          POS_MUX_HIGH     = 17;
	localparam int          POS_DRIVE        = 20;

	// ==========================================================
	// field codes
	localparam logic [1:0]  PRESC_CELL       = 2'h1;
	localparam logic [1:0]  PRESC_PCS        = 2'h2;
	localparam logic [1:0]  VCO_OFF          = 2'h0;
	localparam logic [1:0]  VCO_LOW          = 2'h1;
	localparam logic [1:0]  VCO_HIGH         = 2'h2;
	localparam logic [1:0]  BAND_IMT         = 2'h0;
	localparam logic [1:0]  BAND_PCS         = 2'h1;
	localparam logic [2:0]  BW_WCDMA         = 3'h0;
	localparam logic [2:0]  BW_GSM           = 3'h3;
	localparam logic [1:0]  MUX_RX_LOCK      = 2'h0;
	localparam logic [1:0]  MUX_TX_LOCK      = 2'h1;
	localparam logic [1:0]  MUX_STATIC       = 2'h2;
	localparam logic [1:0]  MUX_ALL_LOCK     = 2'h3;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic       loopFilterAdjust;
		logic [1:0] prescalerCfg;
		logic [1:0] vcoChoice;
		logic [1:0] highVcoBand;
		logic       filterSkip;
		logic [2:0] bandwidthMode;
	} rsfg_rx_cfg_t;

	typedef struct packed {
		logic rxLock;
		logic txLock;
		logic clkLock;
	} rsfg_lock_t;

	typedef enum logic [1:0] {SER_IDLE, SER_HEAD, SER_DATA, SER_DONE} rsfg_ser_state_t;

endpackage

// [dv/rsfg_host.sv]
// host-side model of the four-wire serial port
`timescale 1ns/1ps
module rsfg_host
	import rsfg_pkg::*;
(
	// clock
	input  wire logic ref_clk,
	// serial pins
	output logic      serCsN,
	output logic      serClk,
	output logic      serDin,
	input  wire logic serDout
);
	initial begin
		serCsN = 1'b1;
		serClk = 1'b0;
		serDin = 1'b0;
	end
	// ==========================================================
	// frame: n clocks of {rd, addr, data}; n under 32 aborts it
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [25:0] d,
		input int n, input int hp, output logic [25:0] q);
		logic [31:0] f;
		f = {rd, a, d};
		q = '0;
		serCsN = 1'b0;
		repeat (hp) @(negedge ref_clk);
		for (int i = 0; i < n; i++) begin
			serDin = f[31 - i];
			repeat (hp) @(negedge ref_clk);
			serClk = 1'b1;
			repeat (hp) @(negedge ref_clk);
			// device shifts on each fall, so take the bit before the fall
			if (i >= 5 && i < 31) q = {q[24:0], serDout};
			serClk = 1'b0;
		end
		repeat (hp) @(negedge ref_clk);
		serCsN = 1'b1;
		// a released line must not look like the last bit
		serDin = ~serDin;
		repeat (hp) @(negedge ref_clk);
	endtask
endmodule

// [dv/rsfg_regs_chk.sv]
// concurrent checks on the register slice ports
`timescale 1ns/1ps
module rsfg_regs_chk
	import rsfg_pkg::*;
(
	// clock and reset
	input wire logic         ref_clk,
	input wire logic         reset,
	// watched ports
	input wire logic         serCsN,
	input wire logic         serDoutOe,
	input wire logic [1:0]   serialOutDriveStrength,
	input wire logic         tempReadStart,
	input wire rsfg_rx_cfg_t rxCfg,
	input wire logic         lowBandVcoOn,
	input wire logic         highBandVcoOn,
	input wire logic         cfgFault
);
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ==========================================================
	// decode helpers
	logic badCode;
	assign badCode = rxCfg.loopFilterAdjust || rxCfg.vcoChoice == 2'h3
		|| !(rxCfg.prescalerCfg inside {PRESC_CELL, PRESC_PCS})
		|| !(rxCfg.highVcoBand inside {BAND_IMT, BAND_PCS})
		|| !(rxCfg.bandwidthMode inside {BW_WCDMA, BW_GSM});
	// decoded flags register in the same cycle as the fields; still wait for calm
	sequence calm;
		!$past(reset) && !$past(reset, 2) && $stable(rxCfg);
	endsequence
	// ==========================================================
	// assertions
	a_vco_low_decode: assert property (calm |-> lowBandVcoOn == (rxCfg.vcoChoice == VCO_LOW))
		else $error("low vco enable wrong");
	a_vco_high_decode: assert property (calm |-> highBandVcoOn == (rxCfg.vcoChoice == VCO_HIGH))
		else $error("high vco enable wrong");
	a_fault_decode: assert property (calm |-> cfgFault == badCode)
		else $error("config fault flag wrong");
	a_trig_pulse: assert property (tempReadStart |=> !tempReadStart)
		else $error("temperature start longer than one cycle");
	a_trig_on_write: assert property (tempReadStart |-> !serDoutOe)
		else $error("temperature start during readback");
	a_oe_release: assert property (serCsN [*6] |-> !serDoutOe)
		else $error("data out driven while deselected");
	a_drive_hold: assert property (serCsN [*8] |=> $stable(serialOutDriveStrength))
		else $error("drive strength changed without a frame");
	a_cfg_hold: assert property (serCsN [*8] |=> $stable(rxCfg))
		else $error("receive config changed without a frame");
	c_trig: cover property (tempReadStart);
	c_read: cover property ($rose(serDoutOe));
	c_fault_clear: cover property ($fell(cfgFault));
endmodule

bind rsfg_regs rsfg_regs_chk u_chk (.ref_clk, .reset, .serCsN, .serDoutOe,
	.serialOutDriveStrength, .tempReadStart, .rxCfg, .lowBandVcoOn, .highBandVcoOn, .cfgFault);

// [dv/rsfg_regs_tb.sv]
// self-checking bench for the receive config / output pin register slice
`timescale 1ns/1ps
module rsfg_regs_tb;
	import rsfg_pkg::*;
	// ==========================================================
	// wiring
	logic         ref_clk = 1'b0;
	logic         reset = 1'b1;
	logic         serCsN, serClk, serDin, serDout, serDoutOe;
	logic [1:0]   drv;
	rsfg_lock_t   lockFlags = '0;
	logic         tempReadStart, gTwo, gTwoOe, gThree, gThreeOe, lowOn, highOn, cfgFault;
	logic         tempResultValid = 1'b0;
	logic [4:0]   tempResult = 5'h00;
	logic [4:0]   tempNow = 5'h00;
	rsfg_rx_cfg_t rxCfg;
	logic [25:0]  q, d3, d6, d7;
	int           mismatches = 0;
	int           samples_checked = 0;
	int           trigSeen = 0;
	int           trigExp = 0;
	always #2 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (tempReadStart === 1'b1) trigSeen++;
	rsfg_regs u_dut (.ref_clk(ref_clk), .reset(reset), .serCsN(serCsN), .serClk(serClk),
		.serDin(serDin), .serDout(serDout), .serDoutOe(serDoutOe),
		.serialOutDriveStrength(drv), .lockFlags(lockFlags), .tempReadStart(tempReadStart),
		.tempResultValid(tempResultValid), .tempResult(tempResult),
		.generalOutputTwo(gTwo), .generalOutputTwoOe(gTwoOe), .generalOutputThree(gThree),
		.generalOutputThreeOe(gThreeOe), .rxCfg(rxCfg), .lowBandVcoOn(lowOn),
		.highBandVcoOn(highOn), .cfgFault(cfgFault));
	rsfg_host u_host (.ref_clk(ref_clk), .serCsN(serCsN), .serClk(serClk), .serDin(serDin),
		.serDout(serDout));
	// ==========================================================
	// helpers
	task automatic chk(input logic [25:0] g, input logic [25:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// writes are prompt, reads use the slow serial clock
	task automatic wr(input logic [4:0] a, input logic [25:0] d);
		u_host.xfer(1'b0, a, d, 32, 6, q);
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [25:0] e);
		u_host.xfer(1'b1, a, 26'h0000000, 32, 9, q);
		chk(q, e);
	endtask
	function automatic rsfg_rx_cfg_t expCfg(input logic [25:0] a, input logic [25:0] b);
		return {a[POS_LOOP_FILTER], a[POS_PRESCALER+:2], a[POS_VCO_CHOICE+:2],
			a[POS_HIGH_BAND+:2], b[POS_FILTER_SKIP], b[POS_BW_MODE+:3]};
	endfunction
	function automatic logic [2:0] expDec(input logic [25:0] a, input logic [25:0] b);
		return {a[POS_VCO_CHOICE+:2] == VCO_LOW, a[POS_VCO_CHOICE+:2] == VCO_HIGH,
			a[POS_LOOP_FILTER] || a[POS_VCO_CHOICE+:2] == 2'h3
			|| !(a[POS_PRESCALER+:2] inside {PRESC_CELL, PRESC_PCS})
			|| !(a[POS_HIGH_BAND+:2] inside {BAND_IMT, BAND_PCS})
			|| !(b[POS_BW_MODE+:3] inside {BW_WCDMA, BW_GSM})};
	endfunction
	function automatic logic [3:0] expGpo(input logic [25:0] r, input rsfg_lock_t l);
		logic [1:0] t;
		t = {r[POS_OUT_TWO], r[POS_OUT_TWO + 1]};
		case ({r[POS_MUX_HIGH], r[POS_MUX_LOW]})
			MUX_RX_LOCK: return {t, l.rxLock, 1'b1};
			MUX_TX_LOCK: return {t, l.txLock, 1'b1};
			MUX_STATIC:  return {t, r[POS_OUT_THREE], r[POS_OUT_THREE + 1]};
			default:     return {t, l.rxLock & l.txLock & l.clkLock, 1'b1};
		endcase
	endfunction
	// ==========================================================
	// scenarios
	initial begin
		#250us;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h03C8));
		repeat (4) @(negedge ref_clk);
		reset = 1'b0;
		repeat (3) @(negedge ref_clk);
		for (int a = ADDR_FIRST; a <= ADDR_LAST; a++) rdchk(5'(a), REG_RESET);
		for (int i = 0; i < 8; i++) begin
			d3 = 26'($urandom);
			d6 = 26'($urandom);
			d3[POS_LOOP_FILTER] = i[0];
			d3[POS_PRESCALER+:2] = 2'(i + 1);
			d3[POS_VCO_CHOICE+:2] = 2'(i);
			d3[POS_HIGH_BAND+:2] = 2'(i);
			d6[POS_BW_MODE+:3] = 3'(i);
			wr(ADDR_RX_VCO_CONFIG, d3);
			wr(ADDR_RX_BASEBAND_FILTER, d6);
			chk({15'h0000, rxCfg}, {15'h0000, expCfg(d3, d6)});
			chk({23'h000000, lowOn, highOn, cfgFault}, {23'h000000, expDec(d3, d6)});
			rdchk(ADDR_RX_VCO_CONFIG, d3);
			rdchk(ADDR_RX_BASEBAND_FILTER, d6);
		end
		for (int i = 0; i < 16; i++) begin
			d7 = 26'($urandom);
			{d7[POS_MUX_HIGH], d7[POS_MUX_LOW]} = 2'(i);
			d7[POS_OUT_THREE+:2] = 2'(i >> 2);
			d7[POS_OUT_TWO+:2] = 2'(i + 2);
			lockFlags = rsfg_lock_t'(3'($urandom));
			wr(ADDR_OUTPUT_PIN_CONFIG, d7);
			trigExp += d7[POS_TEMP_TRIG];
			d7[POS_TEMP_RESULT+:5] = tempNow;
			chk({22'h000000, gTwo, gTwoOe, gThree, gThreeOe}, {22'h000000, expGpo(d7, lockFlags)});
			chk({24'h000000, drv}, {24'h000000, d7[POS_DRIVE+:2]});
			chk(26'(trigSeen), 26'(trigExp));
			rdchk(ADDR_OUTPUT_PIN_CONFIG, d7);
		end
		tempResultValid = 1'b1;
		tempResult = 5'($urandom);
		tempNow = tempResult;
		@(negedge ref_clk);
		tempResultValid = 1'b0;
		tempResult = ~tempResult;
		d7[POS_TEMP_RESULT+:5] = tempNow;
		rdchk(ADDR_OUTPUT_PIN_CONFIG, d7);
		wr(ADDR_RESERVED_FOUR, 26'h0C69A10);
		wr(ADDR_RESERVED_FIVE, 26'h00542CF);
		rdchk(ADDR_RESERVED_FOUR, 26'h0C69A10);
		rdchk(ADDR_RESERVED_FIVE, 26'h00542CF);
		wr(5'h08, 26'($urandom));
		rdchk(5'h08, 26'h0000000);
		// frame cut short inside the data bits must leave the register alone
		u_host.xfer(1'b0, ADDR_RX_VCO_CONFIG, ~d3, 20, 6, q);
		rdchk(ADDR_RX_VCO_CONFIG, d3);
		tally_and_finish();
	end
endmodule
